// ===== hdl/sipo_pkg.sv
// Purpose: Shared constants of the serial-in, parallel-out latch.
// Assumes: One system clock; every pin is sampled by it.
// Notes:   Pin positions index the vector handed to the synchroniser.
package sipo_pkg;

   // Data path width: eight shift stages, eight holding bits
   localparam int SIPO_WIDTH = 8;

   // Reset contents of the shift chain and of the holding register
   localparam logic [SIPO_WIDTH-1:0] SIPO_CHAIN_RST = 8'h00;
   localparam logic [SIPO_WIDTH-1:0] SIPO_HOLD_RST  = 8'h00;

   // Positions of the pins in the synchronised pin vector
   localparam int SIPO_PIN_SER   = 0;
   localparam int SIPO_PIN_SCLK  = 1;
   localparam int SIPO_PIN_CLR   = 2;
   localparam int SIPO_PIN_STCLK = 3;
   localparam int SIPO_PIN_OE    = 4;
   localparam int SIPO_PIN_COUNT = 5;

   // Synchroniser reset value: clear and output enable idle high
   localparam logic [SIPO_PIN_COUNT-1:0] SIPO_PIN_RST = 5'h14;

   // Cycles after reset before clock edges are believed
   localparam logic [1:0] SIPO_WARM_CYCLES = 2'h3;

endpackage

// ===== hdl/sipo_chain_if.sv
// Purpose: Carries control and contents between top and shift chain.
// Assumes: All signals live on sys_clk.
// Notes:   shift_pulse is a one-cycle enable taken from a pin edge.
`timescale 1ns/1ps
interface sipo_chain_if
   import sipo_pkg::*;
   ();
   logic                  clear_n;     // Level, low empties the chain
   logic                  shift_pulse; // One-cycle shift enable
   logic                  serial_bit;  // Bit entering stage zero
   logic [SIPO_WIDTH-1:0] stages;      // Stage zero in bit zero

   // Control side, held by the top module
   modport ctrl
   (
      output clear_n,
      output shift_pulse,
      output serial_bit,
      input  stages
   );

   // Storage side, held by the chain
   modport chain
   (
      input  clear_n,
      input  shift_pulse,
      input  serial_bit,
      output stages
   );
endinterface

// ===== hdl/sipo_pin_sync.sv
// Purpose: Two-flop synchroniser for every pin of the latch.
// Assumes: Pins are asynchronous to sys_clk.
// Notes:   The first flop of each bit feeds only the second.
`timescale 1ns/1ps
module sipo_pin_sync
   import sipo_pkg::*;
(
   input  wire logic                      sys_clk,
   input  wire logic                      reset,
   input  wire logic [SIPO_PIN_COUNT-1:0] pin_raw,
   output logic      [SIPO_PIN_COUNT-1:0] pin_sync
);

   // One identical pair of flops per pin
   genvar i;
   generate
      for (i = 0; i < SIPO_PIN_COUNT; i++)
      begin : g_bit
         logic meta_r;   // May be metastable
         logic meta_nxt;
         logic safe_r;   // Settled copy
         logic safe_nxt;

         // Next values; reset loads the idle pin level
         always_comb
         begin
            meta_nxt = reset ? SIPO_PIN_RST[i] : pin_raw[i];
            safe_nxt = reset ? SIPO_PIN_RST[i] : meta_r;
         end

         // Register only
         always_ff @(posedge sys_clk)
         begin
            meta_r <= meta_nxt;
            safe_r <= safe_nxt;
         end

         assign pin_sync[i] = safe_r;
      end
   endgenerate

endmodule

// ===== hdl/sipo_shift_chain.sv
// Purpose: Eight-stage serial-in shift chain with overriding clear.
// Assumes: shift_pulse lasts one cycle per shift clock rise.
// Notes:   Clear wins over a shift arriving in the same cycle.
`timescale 1ns/1ps
module sipo_shift_chain
   import sipo_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   sipo_chain_if.chain ch
);

   logic [SIPO_WIDTH-1:0] stages_r;   // Shift stages
   logic [SIPO_WIDTH-1:0] stages_nxt;

   // Next chain contents
   always_comb
   begin
      if (reset)
         stages_nxt = SIPO_CHAIN_RST;
      else if (!ch.clear_n)
         // Clear overrides any shift
         stages_nxt = SIPO_CHAIN_RST;
      else if (ch.shift_pulse)
         // Stage zero takes the pin, the rest move one up
         stages_nxt = {stages_r[SIPO_WIDTH-2:0], ch.serial_bit};
      else
         stages_nxt = stages_r;
   end

   // Register only
   always_ff @(posedge sys_clk)
   begin
      stages_r <= stages_nxt;
   end

   assign ch.stages = stages_r;

endmodule

// ===== hdl/sipo_latch_top.sv
// Purpose: Serial-in, parallel-out latch with three-state outputs.
// Assumes: Host drives all pins asynchronously to sys_clk.
// Notes:   Pin clocks are sampled; edges become one-cycle enables.
`timescale 1ns/1ps
module sipo_latch_top
   import sipo_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic                  serial_data_in,
   input  wire logic                  shift_clock,
   input  wire logic                  shift_clear_n,
   input  wire logic                  storage_clock,
   input  wire logic                  output_enable_n,
   output logic      [SIPO_WIDTH-1:0] parallel_out,
   output logic      [SIPO_WIDTH-1:0] parallel_out_oe,
   output logic                       cascade_serial_out
);

   // Raw and synchronised pins
   logic [SIPO_PIN_COUNT-1:0] pin_raw;
   logic [SIPO_PIN_COUNT-1:0] pin_sync;

   // Named views of the settled pins
   logic ser_s;    // Serial data
   logic sclk_s;   // Shift clock level
   logic clr_n_s;  // Clear, active low
   logic stclk_s;  // Holding clock level
   logic oe_n_s;   // Output enable, active low

   // Previous clock levels for edge finding
   logic sclk_prev_r;
   logic sclk_prev_nxt;
   logic stclk_prev_r;
   logic stclk_prev_nxt;

   // Warm-up counter after reset
   logic [1:0] warm_r;
   logic [1:0] warm_nxt;
   logic       armed;

   // One-cycle enables from the pin clocks
   logic shift_pulse;
   logic store_pulse;

   // Holding register and output enable state
   logic [SIPO_WIDTH-1:0] hold_r;
   logic [SIPO_WIDTH-1:0] hold_nxt;
   logic [SIPO_WIDTH-1:0] oe_r;
   logic [SIPO_WIDTH-1:0] oe_nxt;

   // Link between top and shift chain
   sipo_chain_if ch ();

   // A rising edge counts only once the synchronisers hold real pin
   // levels; this stops a clock parked high at reset from shifting.
   function automatic logic edge_rise
   (
      input logic cur,
      input logic prev,
      input logic arm
   );
      edge_rise = arm & cur & ~prev;
   endfunction

   // Gather pins into one vector for the synchroniser
   assign pin_raw[SIPO_PIN_SER]   = serial_data_in;
   assign pin_raw[SIPO_PIN_SCLK]  = shift_clock;
   assign pin_raw[SIPO_PIN_CLR]   = shift_clear_n;
   assign pin_raw[SIPO_PIN_STCLK] = storage_clock;
   assign pin_raw[SIPO_PIN_OE]    = output_enable_n;

   // Data and clock share the same depth, so the data sampled with
   // an edge is the level the host set up before that edge.
   sipo_pin_sync u_sync
   (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .pin_raw  (pin_raw),
      .pin_sync (pin_sync)
   );

   assign ser_s   = pin_sync[SIPO_PIN_SER];
   assign sclk_s  = pin_sync[SIPO_PIN_SCLK];
   assign clr_n_s = pin_sync[SIPO_PIN_CLR];
   assign stclk_s = pin_sync[SIPO_PIN_STCLK];
   assign oe_n_s  = pin_sync[SIPO_PIN_OE];

   // Next values of warm-up and edge history
   always_comb
   begin
      if (reset)
      begin
         warm_nxt       = 2'h0;
         sclk_prev_nxt  = 1'b0;
         stclk_prev_nxt = 1'b0;
      end
      else
      begin
         // Count up and stop at the limit
         warm_nxt       = armed ? warm_r : warm_r + 2'h1;
         sclk_prev_nxt  = sclk_s;
         stclk_prev_nxt = stclk_s;
      end
   end

   // Register only
   always_ff @(posedge sys_clk)
   begin
      warm_r       <= warm_nxt;
      sclk_prev_r  <= sclk_prev_nxt;
      stclk_prev_r <= stclk_prev_nxt;
   end

   assign armed = (warm_r == SIPO_WARM_CYCLES);

   // Pin clocks must stay high and low for about two system cycles
   // each, or the edge finder can miss a pulse.
   // Each clock has its own edge finder; falling edges do nothing
   assign shift_pulse = edge_rise(sclk_s, sclk_prev_r, armed);
   assign store_pulse = edge_rise(stclk_s, stclk_prev_r, armed);

   // Drive the chain; clear is a level, not gated by any clock
   // Clear acts on the settled level, so it lands two to three
   // cycles after the pin falls; a shorter low pulse may be missed.
   assign ch.clear_n     = clr_n_s;
   assign ch.shift_pulse = shift_pulse;
   assign ch.serial_bit  = ser_s;

   // The eight shift stages
   sipo_shift_chain u_chain
   (
      .sys_clk (sys_clk),
      .reset   (reset),
      .ch      (ch.chain)
   );

   // Next holding register and output enable
   always_comb
   begin
      hold_nxt = hold_r;
      oe_nxt   = oe_r;
      if (reset)
      begin
         hold_nxt = SIPO_HOLD_RST;
         oe_nxt   = {SIPO_WIDTH{1'b0}};
      end
      else
      begin
         // Copy reads the chain before this cycle's shift lands, so
         // tied clocks leave the chain one pulse ahead. Clear is
         // not looked at here: only a holding edge changes it.
         if (store_pulse)
            hold_nxt = ch.stages;
         // Enable low drives all eight pins, high floats them
         oe_nxt = {SIPO_WIDTH{~oe_n_s}};
      end
   end

   // Register only
   always_ff @(posedge sys_clk)
   begin
      hold_r <= hold_nxt;
      oe_r   <= oe_nxt;
   end

   // Outputs come straight from flops
   assign parallel_out       = hold_r;
   assign parallel_out_oe    = oe_r;
   // Last stage, not gated by the output enable
   assign cascade_serial_out = ch.stages[SIPO_WIDTH-1];

   // Checks on the behaviour above
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   // A settled shift clock going from low to high
   sequence s_sclk_rise;
      !sclk_s ##1 sclk_s;
   endsequence

   // A settled holding clock going from low to high
   sequence s_stclk_rise;
      !stclk_s ##1 stclk_s;
   endsequence

   // Shift clock rise with clear idle, once armed
   sequence s_shift_ok;
      s_sclk_rise ##0 (clr_n_s && armed);
   endsequence

   // Stage zero must hold the data that stood at the shift edge
   a_stage_zero_in: assert property (
      s_shift_ok |=> ch.stages[0] == $past(ser_s))
      else $error("stage zero missed serial data");

   // Every other stage takes its neighbour's old value
   a_stages_move: assert property (
      s_shift_ok |=> ch.stages[SIPO_WIDTH-1:1] == $past(ch.stages[SIPO_WIDTH-2:0]))
      else $error("stages did not move up by one");

   // Clear is a level: the cycle after every cycle it stands, the chain is empty
   a_clear_empties: assert property (
      !clr_n_s |=> ch.stages == SIPO_CHAIN_RST)
      else $error("clear did not empty the chain");

   // A falling shift clock must not move anything
   a_falling_still: assert property (
      (sclk_prev_r && !sclk_s && clr_n_s) |=> $stable(ch.stages))
      else $error("chain changed on a falling edge");

   // A holding edge copies the chain as it stood at that edge
   a_hold_copy: assert property (
      (s_stclk_rise ##0 armed) |=> parallel_out == $past(ch.stages))
      else $error("holding register missed the chain");

   // Both enables in one cycle: holding takes the pre-shift chain
   a_tied_ahead: assert property (
      (s_shift_ok ##0 store_pulse)
      |=> parallel_out[SIPO_WIDTH-2:0] == ch.stages[SIPO_WIDTH-1:1])
      else $error("tied clocks did not leave chain one ahead");

   // Clear alone never reaches the holding bits; a holding edge
   // during clear is legal and copies the chain, empty from clear's second cycle on
   a_clear_keeps_hold: assert property (
      (!clr_n_s && !store_pulse) |=> $stable(parallel_out))
      else $error("clear disturbed the holding register");

   // Enable low drives all eight pins one cycle later
   a_enable_drive: assert property (
      !oe_n_s |=> parallel_out_oe == {SIPO_WIDTH{1'b1}})
      else $error("parallel pins not driven while enabled");

   // Enable high floats them whatever the clocks do
   a_enable_float: assert property (
      oe_n_s |=> parallel_out_oe == {SIPO_WIDTH{1'b0}})
      else $error("parallel pins driven while disabled");

   // Cascade keeps following the chain while the pins float
   a_cascade_live: assert property (
      (s_shift_ok ##0 oe_n_s)
      |=> cascade_serial_out == $past(ch.stages[SIPO_WIDTH-2]))
      else $error("cascade output stopped while disabled");

   // Cascade follows the chain in every shift, enabled or not
   a_cascade_follows: assert property (
      s_shift_ok |=> cascade_serial_out == $past(ch.stages[SIPO_WIDTH-2]))
      else $error("cascade output missed a shift");

   // A pin edge gives one enable, however long the pin stays high
   a_edge_spacing: assert property (
      shift_pulse |=> !shift_pulse)
      else $error("shift enable lasted more than one cycle");

   // Without a shift enable or clear the chain holds still, so a
   // holding edge alone can never shift
   a_chain_own_clock: assert property (
      (!shift_pulse && clr_n_s) |=> $stable(ch.stages))
      else $error("chain moved without a shift edge");

   // Without a holding enable the holding bits hold still
   a_hold_own_clock: assert property (
      !store_pulse |=> $stable(parallel_out))
      else $error("holding register moved without a holding edge");

   // A falling holding clock must not copy anything
   a_store_fall_still: assert property (
      (stclk_prev_r && !stclk_s) |=> $stable(parallel_out))
      else $error("holding register changed on a falling edge");

   // Clear empties the last stage, so the cascade pin drops too
   a_cascade_cleared: assert property (
      !clr_n_s |=> !cascade_serial_out)
      else $error("cascade output not cleared");

   // A holding edge with no shift: copy lands, chain stays put
   sequence s_store_alone;
      s_stclk_rise ##0 (armed && clr_n_s && !shift_pulse);
   endsequence

   a_store_alone: assert property (
      s_store_alone |=> parallel_out == $past(ch.stages) && $stable(ch.stages))
      else $error("lone holding edge disturbed the chain");

   // Reset empties chain and holding bits and floats the pins; the
   // default disable is overridden so the check runs during reset
   a_reset_clean: assert property (
      disable iff (1'b0)
      reset |=> ch.stages == SIPO_CHAIN_RST && parallel_out == SIPO_HOLD_RST && parallel_out_oe == '0)
      else $error("reset left state behind");

endmodule

// ===== tb/sipo_host_model.sv
// Purpose: Host controller that drives the latch pins from its own timing.
// Assumes: Link clock period 125 ns, unrelated in phase to sys_clk.
// Notes:   Pin clocks stand low between frames; data is inverted once its hold ends.
`timescale 1ns/1ps
module sipo_host_model
   import sipo_pkg::*;
(
   output logic serial_data_in,
   output logic shift_clock,
   output logic shift_clear_n,
   output logic storage_clock,
   output logic output_enable_n
);
   // Idle pins: clocks low, clear inactive, outputs floating
   initial
   begin
      serial_data_in  = 1'b0;
      shift_clock     = 1'b0;
      shift_clear_n   = 1'b1;
      storage_clock   = 1'b0;
      output_enable_n = 1'b1;
   end

   // One bit per 125 ns period; tie also raises the holding clock with it
   task automatic shift_bit(input logic b, input logic tie);
      serial_data_in = b;
      #30;
      shift_clock   = 1'b1;
      storage_clock = tie;
      #62.5;
      shift_clock   = 1'b0;
      storage_clock = 1'b0;
      // Hold time over: show the inverse so stale data cannot pass;
      // the next bit replaces it only after the rest of the period
      serial_data_in = ~b;
      #32.5;
   endtask

   // Holding clock alone, one full period
   task automatic store_pulse();
      storage_clock = 1'b1;
      #62.5;
      storage_clock = 1'b0;
      #62.5;
   endtask

   // Level changes, then one period for the synchroniser to settle
   task automatic set_clear(input logic lvl);
      shift_clear_n = lvl;
      #125;
   endtask

   task automatic set_oe(input logic lvl);
      output_enable_n = lvl;
      #125;
   endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench of the serial-in, parallel-out latch.
// Assumes: Host model makes all pin timing; bench keeps a model chain.
// Notes:   Parallel pins are resolved from the per-bit enables.
`timescale 1ns/1ps
module tb_top
   import sipo_pkg::*;
;
   logic                  sys_clk = 1'b0; // 100 MHz system clock
   logic                  reset   = 1'b1; // Synchronous, active high
   logic                  ser_w, sclk_w, clr_n_w, stclk_w, oe_n_w;
   logic [SIPO_WIDTH-1:0] par;            // Holding value from design
   logic [SIPO_WIDTH-1:0] par_oe;         // Per-bit drive enable
   logic                  casc;           // Cascade output
   wire  [SIPO_WIDTH-1:0] pins;           // Resolved parallel wire
   logic [SIPO_WIDTH-1:0] exp_chain = 8'h00; // Expected shift stages
   logic [SIPO_WIDTH-1:0] exp_hold  = 8'h00; // Expected holding bits
   int                    failures  = 0;
   int                    tests_run = 0;
   int                    cycles    = 0;

   always #5 sys_clk = ~sys_clk;

   // Undriven bits float, so a missing enable shows as z
   for (genvar i = 0; i < SIPO_WIDTH; i++)
   begin : g_pin
      assign pins[i] = par_oe[i] ? par[i] : 1'bz;
   end

   sipo_host_model i_host (.serial_data_in(ser_w), .shift_clock(sclk_w), .shift_clear_n(clr_n_w),
      .storage_clock(stclk_w), .output_enable_n(oe_n_w));

   sipo_latch_top i_dut (.sys_clk(sys_clk), .reset(reset), .serial_data_in(ser_w), .shift_clock(sclk_w),
      .shift_clear_n(clr_n_w), .storage_clock(stclk_w), .output_enable_n(oe_n_w), .parallel_out(par),
      .parallel_out_oe(par_oe), .cascade_serial_out(casc));

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk8(input logic [SIPO_WIDTH-1:0] got, input logic [SIPO_WIDTH-1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t parallel pins %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t cascade %b expected %b", $time, got, exp);
      end
   endtask

   // One shift through the host; the model chain follows, clear wins
   task automatic sh(input logic b, input logic tie);
      i_host.shift_bit(b, tie);
      if (tie)
         exp_hold = exp_chain;
      if (clr_n_w)
         exp_chain = {exp_chain[SIPO_WIDTH-2:0], b};
      chk1(casc, exp_chain[SIPO_WIDTH-1]);
   endtask

   // Full byte, first bit ending in the last stage, then a store
   task automatic t_byte(input logic [SIPO_WIDTH-1:0] v);
      for (int i = SIPO_WIDTH - 1; i >= 0; i--)
         sh(v[i], 1'b0);
      i_host.store_pulse();
      exp_hold = exp_chain;
      chk8(pins, exp_hold);
   endtask

   // Outputs float when disabled, cascade keeps driving
   task automatic t_oe();
      i_host.set_oe(1'b1);
      sh(1'b1, 1'b0);
      chk8(pins, 8'hzz);
      chk1(casc, exp_chain[SIPO_WIDTH-1]);
      i_host.set_oe(1'b0);
      chk8(pins, exp_hold);
   endtask

   // Clear empties the chain, overrides a shift, spares the holding bits
   task automatic t_clear();
      i_host.set_clear(1'b0);
      exp_chain = 8'h00;
      chk1(casc, 1'b0);
      sh(1'b1, 1'b0);
      chk8(pins, exp_hold);
      i_host.set_clear(1'b1);
      i_host.store_pulse();
      exp_hold = 8'h00;
      chk8(pins, exp_hold);
   endtask

   // Tied clocks: holding register takes the chain before the shift
   task automatic t_tied();
      t_byte(8'h3c);
      sh(1'b1, 1'b1);
      chk8(pins, exp_hold);
      sh(1'b0, 1'b1);
      chk8(pins, exp_hold);
   endtask

   // Ceiling well above the roughly 475 cycles the run needs
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         conclude();
      end
   end

   // Main sequence
   initial
   begin
      repeat (5) @(posedge sys_clk);
      #1 reset = 1'b0;
      repeat (8) @(posedge sys_clk);
      // Start off the edge so no host pin moves with a rising clock
      #1;
      i_host.set_oe(1'b0);
      t_byte(8'ha5);
      t_byte(8'h5a);
      t_oe();
      t_clear();
      t_tied();
      conclude();
   end
endmodule
